// ---- src/twxse_core.sv ----
// Purpose: executes table write, test-and-skip, both xors and the pointer literal ops
// Assumes: Avalon-MM slave, software loads an opcode into the instruction register
// Notes: writes stall while an instruction runs; reads answer one clock after request
// Operation
// - two low opcode bits pick pointer update mode
// - latch goes to holding register pointer[2:0]
// - table pointer is 21 bits, byte addressed
// - pointer bit zero picks low or high byte; the core has no such select, pointer[2:0] picks one of eight holding bytes
// - test-and-skip opcode decoded; status flags untouched
// - zero register skips next instruction, two cycles
// - skip over two-word instruction takes three cycles
// - access bit zero access bank, one banked
// - extended mode, low addresses become indexed offsets
// - xor literal into working register
// - xor register, destination bit picks target
// - xors update only negative and zero flags
// - extension disabled until its configuration bit set
// - extension adds pointer literal instructions
// - pointer add/sub return forms reload program counter
`timescale 1ns/1ns
`default_nettype none
module twxse_core (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  localparam int unsigned TW = twxse_pkg::TP_W;
  logic ext_q, ext_d, go_q, go_d, z_q, z_d, n_q, n_d, skip_q, skip_d, ack_q, ack_d;
  logic [15:0] op_q, op_d, nxt_q, nxt_d;
  logic [7:0] w_q, w_d, lat_q, lat_d, tmp_q, tmp_d;
  logic [3:0] bank_q, bank_d;
  logic [TW-1:0] tp_q, tp_d, pc_q, pc_d, tos_q, tos_d;
  logic [11:0] ptr_q [3];
  logic [11:0] ptr_d [3];
  logic [11:0] da_q, da_d;
  logic [1:0] ncyc_q, ncyc_d;
  logic [31:0] rd_q, rd_d, rv, mw;
  logic [7:0] dmem [4096];
  logic [7:0] hold [8];
  logic dm_we, hold_we;
  logic [11:0] dm_wa;
  logic [7:0] dm_wd, dval, xres;
  logic [2:0] hold_wi;
  logic seq_busy, busy_all, wr_ok, act0, act1, rdlat, is_xor;
  logic [1:0] seq_q, seq_cyc, start_cyc;
  twxse_dec_if dif ();
  twxse_decode u_dec (
    .d(dif.dec)
  );
  twxse_qseq u_seq (
    .clk(CLK),
    .reset(RESET),
    .start(go_q),
    .ncyc(start_cyc),
    .busy(seq_busy),
    .qph(seq_q),
    .cyc(seq_cyc)
  );
  assign dif.opcode = op_q;
  assign dif.next_op = nxt_q;
  assign dif.ext_en = ext_q;
  assign dif.bank = bank_q;
  assign dif.fsr2 = ptr_q[2];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  assign busy_all = go_q || seq_busy;
  assign wr_ok = AVS_WRITE && !busy_all;
  // a write during execution is held off rather than dropped
  assign AVS_WAITREQUEST = (AVS_READ && !ack_q) || (AVS_WRITE && busy_all);
  assign AVS_READDATA = rd_q;
  assign act0 = seq_busy && seq_q == twxse_pkg::Q_LAST && seq_cyc == 2'h0;
  assign act1 = seq_busy && seq_q == twxse_pkg::Q_LAST && seq_cyc == 2'h1;
  assign rdlat = seq_busy && seq_q == twxse_pkg::Q_READ && seq_cyc == 2'h1;
  assign dval = dmem[dif.data_addr];
  assign is_xor = dif.kind == twxse_pkg::K_XOR_LIT || dif.kind == twxse_pkg::K_XOR_REG;
  assign xres = w_q ^ ((dif.kind == twxse_pkg::K_XOR_LIT) ? dif.lit8 : dval);
  // the skip length is only known once the tested register has been read
  assign start_cyc = (dif.kind == twxse_pkg::K_TST && dval == 8'h00)
                   ? (dif.next_two_word ? twxse_pkg::CYC_THREE : twxse_pkg::CYC_TWO)
                   : dif.cycles;

  always_comb begin
    rv = 32'h0;
    case (AVS_ADDRESS)
      twxse_pkg::OFS_CTRL: rv[twxse_pkg::CTRL_EXT_BIT] = ext_q;
      twxse_pkg::OFS_INSTR: rv[15:0] = op_q;
      twxse_pkg::OFS_NEXT: rv[15:0] = nxt_q;
      twxse_pkg::OFS_WREG: rv[7:0] = w_q;
      twxse_pkg::OFS_STATUS: begin
        rv[twxse_pkg::ST_BUSY_BIT] = busy_all;
        rv[twxse_pkg::ST_Z_BIT] = z_q;
        rv[twxse_pkg::ST_N_BIT] = n_q;
        rv[twxse_pkg::ST_SKIP_BIT] = skip_q;
        rv[twxse_pkg::ST_CYC_LSB +: 2] = ncyc_q;
      end
      twxse_pkg::OFS_TBL_PTR: rv[TW-1:0] = tp_q;
      twxse_pkg::OFS_TBLLAT: rv[7:0] = lat_q;
      twxse_pkg::OFS_BANK: rv[3:0] = bank_q;
      twxse_pkg::OFS_FSR0: rv[11:0] = ptr_q[0];
      twxse_pkg::OFS_FSR1: rv[11:0] = ptr_q[1];
      twxse_pkg::OFS_FSR2: rv[11:0] = ptr_q[2];
      twxse_pkg::OFS_PC: rv[TW-1:0] = pc_q;
      twxse_pkg::OFS_TOS: rv[TW-1:0] = tos_q;
      twxse_pkg::OFS_DADDR: rv[11:0] = da_q;
      twxse_pkg::OFS_DDATA: rv[7:0] = dmem[da_q];
      default: begin
        if (AVS_ADDRESS[7:5] == twxse_pkg::OFS_HOLD0[7:5]) begin
          rv[7:0] = hold[AVS_ADDRESS[4:2]];
        end
      end
    endcase
    mw = merge(rv, AVS_WRITEDATA, AVS_BYTEENABLE);
  end

  always_comb begin
    ext_d = ext_q;
    go_d = 1'b0;
    z_d = z_q;
    n_d = n_q;
    skip_d = skip_q;
    op_d = op_q;
    nxt_d = nxt_q;
    w_d = w_q;
    lat_d = lat_q;
    tmp_d = tmp_q;
    bank_d = bank_q;
    tp_d = tp_q;
    pc_d = pc_q;
    tos_d = tos_q;
    ptr_d = ptr_q;
    da_d = da_q;
    ncyc_d = ncyc_q;
    ack_d = AVS_READ && !ack_q;
    rd_d = ack_q ? rd_q : rv;
    dm_we = 1'b0;
    dm_wa = da_q;
    dm_wd = mw[7:0];
    hold_we = 1'b0;
    hold_wi = tp_q[2:0];
    if (wr_ok) begin
      case (AVS_ADDRESS)
        twxse_pkg::OFS_CTRL: ext_d = mw[twxse_pkg::CTRL_EXT_BIT];
        twxse_pkg::OFS_INSTR: begin
          op_d = mw[15:0];
          go_d = 1'b1;
        end
        twxse_pkg::OFS_NEXT: nxt_d = mw[15:0];
        twxse_pkg::OFS_WREG: w_d = mw[7:0];
        twxse_pkg::OFS_STATUS: begin
          z_d = mw[twxse_pkg::ST_Z_BIT];
          n_d = mw[twxse_pkg::ST_N_BIT];
        end
        twxse_pkg::OFS_TBL_PTR: tp_d = mw[TW-1:0];
        twxse_pkg::OFS_TBLLAT: lat_d = mw[7:0];
        twxse_pkg::OFS_BANK: bank_d = mw[3:0];
        twxse_pkg::OFS_FSR0: ptr_d[0] = mw[11:0];
        twxse_pkg::OFS_FSR1: ptr_d[1] = mw[11:0];
        twxse_pkg::OFS_FSR2: ptr_d[2] = mw[11:0];
        twxse_pkg::OFS_PC: pc_d = mw[TW-1:0];
        twxse_pkg::OFS_TOS: tos_d = mw[TW-1:0];
        twxse_pkg::OFS_DADDR: da_d = mw[11:0];
        twxse_pkg::OFS_DDATA: dm_we = 1'b1;
        default: ;
      endcase
    end
    if (go_q) begin
      ncyc_d = start_cyc;
      skip_d = dif.kind == twxse_pkg::K_TST && dval == 8'h00;
    end
    if (act0) begin
      pc_d = pc_q + twxse_pkg::PC_WORD;
      if (skip_q) begin
        pc_d = pc_q + twxse_pkg::PC_WORD + (dif.next_two_word ? (twxse_pkg::PC_WORD << 1)
                                                            : twxse_pkg::PC_WORD);
      end
      case (dif.kind)
        twxse_pkg::K_TBL_WRITE: begin
          if (dif.tbl_mode == twxse_pkg::TBL_PREINC) begin
            tp_d = tp_q + twxse_pkg::TP_ONE;
          end
        end
        twxse_pkg::K_XOR_LIT: w_d = xres;
        twxse_pkg::K_XOR_REG: begin
          if (dif.dest_f) begin
            dm_we = 1'b1;
            dm_wa = dif.data_addr;
            dm_wd = xres;
          end else begin
            w_d = xres;
          end
        end
        twxse_pkg::K_ADD_PTR: ptr_d[dif.ptr_sel] = ptr_q[dif.ptr_sel] + {6'h0, dif.lit6};
        twxse_pkg::K_SUB_PTR: ptr_d[dif.ptr_sel] = ptr_q[dif.ptr_sel] - {6'h0, dif.lit6};
        twxse_pkg::K_ADDRET: begin
          ptr_d[2] = ptr_q[2] + {6'h0, dif.lit6};
          pc_d = tos_q;
        end
        twxse_pkg::K_SUBRET: begin
          ptr_d[2] = ptr_q[2] - {6'h0, dif.lit6};
          pc_d = tos_q;
        end
        default: ;
      endcase
      if (is_xor) begin
        z_d = xres == 8'h00;
        n_d = xres[7];
      end
    end
    if (rdlat && dif.kind == twxse_pkg::K_TBL_WRITE) begin
      tmp_d = lat_q;
    end
    if (act1 && dif.kind == twxse_pkg::K_TBL_WRITE) begin
      hold_we = 1'b1;
      case (dif.tbl_mode)
        twxse_pkg::TBL_POSTINC: tp_d = tp_q + twxse_pkg::TP_ONE;
        twxse_pkg::TBL_POSTDEC: tp_d = tp_q - twxse_pkg::TP_ONE;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ext_q <= twxse_pkg::RST_EXT;
      go_q <= 1'b0;
      z_q <= 1'b0;
      n_q <= 1'b0;
      skip_q <= 1'b0;
      ack_q <= 1'b0;
      op_q <= twxse_pkg::RST_OP;
      nxt_q <= twxse_pkg::RST_OP;
      w_q <= twxse_pkg::RST_BYTE;
      lat_q <= twxse_pkg::RST_BYTE;
      tmp_q <= twxse_pkg::RST_BYTE;
      bank_q <= 4'h0;
      tp_q <= twxse_pkg::RST_ADDR21;
      pc_q <= twxse_pkg::RST_ADDR21;
      tos_q <= twxse_pkg::RST_ADDR21;
      for (int i = 0; i < 3; i++) begin
        ptr_q[i] <= twxse_pkg::RST_ADDR12;
      end
      da_q <= twxse_pkg::RST_ADDR12;
      ncyc_q <= twxse_pkg::CYC_ONE;
      rd_q <= 32'h0;
    end else begin
      ext_q <= ext_d;
      go_q <= go_d;
      z_q <= z_d;
      n_q <= n_d;
      skip_q <= skip_d;
      ack_q <= ack_d;
      op_q <= op_d;
      nxt_q <= nxt_d;
      w_q <= w_d;
      lat_q <= lat_d;
      tmp_q <= tmp_d;
      bank_q <= bank_d;
      tp_q <= tp_d;
      pc_q <= pc_d;
      tos_q <= tos_d;
      ptr_q <= ptr_d;
      da_q <= da_d;
      ncyc_q <= ncyc_d;
      rd_q <= rd_d;
    end
  end

  // holding registers start erased so a partial block programs as blank
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 8; i++) begin
        hold[i] <= twxse_pkg::RST_HOLD;
      end
    end else if (hold_we) begin
      hold[hold_wi] <= tmp_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (dm_we) begin
      dmem[dm_wa] <= dm_wd;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence run_two_s;
    seq_busy [*8] ##1 !seq_busy;
  endsequence
  sequence run_three_s;
    seq_busy [*8] ##1 seq_busy [*4] ##1 !seq_busy;
  endsequence
  postinc_step_a: assert property (act1 && dif.kind == twxse_pkg::K_TBL_WRITE
      && dif.tbl_mode == twxse_pkg::TBL_POSTINC |=> tp_q == $past(tp_q) + twxse_pkg::TP_ONE)
    else $error("post-increment did not step the table pointer");
  hold_index_a: assert property (hold_we |=> hold[$past(tp_q[2:0])] == $past(tmp_q))
    else $error("holding register index not taken from pointer");
  ptr_wrap_a: assert property (act1 && dif.kind == twxse_pkg::K_TBL_WRITE
      && dif.tbl_mode == twxse_pkg::TBL_POSTDEC && tp_q == 21'h000000 |=> tp_q == 21'h1fffff)
    else $error("table pointer did not wrap on decrement");
  tst_flags_a: assert property (go_q && dif.kind == twxse_pkg::K_TST
      |-> ##1 ($stable(z_q) && $stable(n_q)) [*4])
    else $error("test-and-skip disturbed the flags");
  skip_two_a: assert property (go_q && dif.kind == twxse_pkg::K_TST && dval == 8'h00
      && !dif.next_two_word |-> ##1 run_two_s)
    else $error("skip did not take two cycles");
  skip_three_a: assert property (go_q && dif.kind == twxse_pkg::K_TST && dval == 8'h00
      && dif.next_two_word |-> ##1 run_three_s)
    else $error("skip over two-word instruction did not take three cycles");
  bank_addr_a: assert property (dif.kind == twxse_pkg::K_XOR_REG && op_q[8]
      |-> dif.data_addr == {bank_q, op_q[7:0]})
    else $error("banked address wrong");
  index_addr_a: assert property (ext_q && !op_q[8] && op_q[7:0] <= twxse_pkg::ACCESS_SPLIT
      |-> dif.data_addr == ptr_q[2] + {4'h0, op_q[7:0]})
    else $error("indexed literal offset address wrong");
  xor_lit_a: assert property (act0 && dif.kind == twxse_pkg::K_XOR_LIT
      |=> w_q == ($past(w_q) ^ $past(op_q[7:0])))
    else $error("literal xor result wrong");
  xor_dest_a: assert property (act0 && dif.kind == twxse_pkg::K_XOR_REG && dif.dest_f
      |=> w_q == $past(w_q))
    else $error("register xor disturbed the working register");
  xor_flags_a: assert property (act0 && is_xor
      |=> z_q == ($past(xres) == 8'h00) && n_q == $past(xres[7]))
    else $error("xor flags wrong");
  ext_off_a: assert property (!ext_q && op_q[15:9] == twxse_pkg::OPC_ADD_PTR[7:1]
      |-> dif.kind == twxse_pkg::K_NOP)
    else $error("extended opcode decoded while disabled");
  ret_pc_a: assert property (act0 && (dif.kind == twxse_pkg::K_ADDRET
      || dif.kind == twxse_pkg::K_SUBRET) |=> pc_q == $past(tos_q))
    else $error("return form did not reload the program counter");
  tbl_len_a: assert property (go_q && dif.kind == twxse_pkg::K_TBL_WRITE |-> ##1 run_two_s)
    else $error("table write not two cycles");
endmodule : twxse_core
`default_nettype wire

// ---- src/twxse_dec_if.sv ----
// Purpose: carries opcode context into the decoder and decoded fields back out
// Assumes: purely combinational traffic on the core clock
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface twxse_dec_if;
  logic [15:0] opcode;
  logic [15:0] next_op;
  logic ext_en;
  logic [3:0] bank;
  logic [11:0] fsr2;
  twxse_pkg::twxse_kind_t kind;
  logic [1:0] tbl_mode;
  logic dest_f;
  logic [1:0] ptr_sel;
  logic [5:0] lit6;
  logic [7:0] lit8;
  logic [11:0] data_addr;
  logic [1:0] cycles;
  logic next_two_word;
  modport dec (input opcode, next_op, ext_en, bank, fsr2, output kind, tbl_mode, dest_f,
    ptr_sel, lit6, lit8, data_addr, cycles, next_two_word);
  modport core (output opcode, next_op, ext_en, bank, fsr2, input kind, tbl_mode, dest_f,
    ptr_sel, lit6, lit8, data_addr, cycles, next_two_word);
endinterface : twxse_dec_if
`default_nettype wire

// ---- src/twxse_decode.sv ----
// Purpose: classify the opcode, resolve the data address and the base cycle count
// Assumes: opcode and context stable while the core reads the results
// Notes: extended opcodes decode as no-operation unless the extension is enabled
`timescale 1ns/1ns
`default_nettype none
module twxse_decode (
  twxse_dec_if.dec d
);
  logic [7:0] f;
  always_comb begin
    f = d.opcode[7:0];
    d.kind = twxse_pkg::K_NOP;
    d.tbl_mode = d.opcode[1:0];
    d.dest_f = d.opcode[9];
    d.ptr_sel = d.opcode[7:6];
    d.lit6 = d.opcode[5:0];
    d.lit8 = f;
    d.cycles = twxse_pkg::CYC_ONE;
    if (d.opcode[15:2] == twxse_pkg::OPC_TBL_WRITE) begin
      d.kind = twxse_pkg::K_TBL_WRITE;
      d.cycles = twxse_pkg::CYC_TWO;
    end else if (d.opcode[15:9] == twxse_pkg::OPC_TEST_SKIP) begin
      d.kind = twxse_pkg::K_TST;
    end else if (d.opcode[15:8] == twxse_pkg::OPC_XOR_LIT) begin
      d.kind = twxse_pkg::K_XOR_LIT;
    end else if (d.opcode[15:10] == twxse_pkg::OPC_XOR_REG) begin
      d.kind = twxse_pkg::K_XOR_REG;
    end else if (d.ext_en && d.opcode[15:8] == twxse_pkg::OPC_ADD_PTR) begin
      // select 3 is the return form, which always works on pointer 2
      d.kind = (d.ptr_sel == twxse_pkg::PTR_RETURN) ? twxse_pkg::K_ADDRET
                                                    : twxse_pkg::K_ADD_PTR;
      d.cycles = (d.ptr_sel == twxse_pkg::PTR_RETURN) ? twxse_pkg::CYC_TWO : twxse_pkg::CYC_ONE;
    end else if (d.ext_en && d.opcode[15:8] == twxse_pkg::OPC_SUB_PTR) begin
      d.kind = (d.ptr_sel == twxse_pkg::PTR_RETURN) ? twxse_pkg::K_SUBRET
                                                    : twxse_pkg::K_SUB_PTR;
      d.cycles = (d.ptr_sel == twxse_pkg::PTR_RETURN) ? twxse_pkg::CYC_TWO : twxse_pkg::CYC_ONE;
    end
    if (d.opcode[8]) begin
      d.data_addr = {d.bank, f};
    end else if (d.ext_en && f <= twxse_pkg::ACCESS_SPLIT) begin
      d.data_addr = d.fsr2 + {4'h0, f};
    end else if (f <= twxse_pkg::ACCESS_SPLIT) begin
      d.data_addr = {4'h0, f};
    end else begin
      d.data_addr = {twxse_pkg::ACCESS_HI, f};
    end
    d.next_two_word = (d.next_op[15:12] == twxse_pkg::OPC_MOVFF)
                   || (d.next_op[15:9] == twxse_pkg::OPC_CALL)
                   || (d.next_op[15:8] == twxse_pkg::OPC_LFSR)
                   || (d.next_op[15:8] == twxse_pkg::OPC_GOTO)
                   || (d.ext_en && d.next_op[15:8] == twxse_pkg::OPC_MOVS);
  end
endmodule : twxse_decode
`default_nettype wire

// ---- src/twxse_pkg.sv ----
// Purpose: shared constants and types of the table-write / xor / skip execution slice
// Assumes: byte-addressed Avalon-MM register window, one aligned 32-bit word per register
// Notes: one instruction cycle is four core clocks (phases 0..3)
package twxse_pkg;
  localparam int unsigned TP_W = 21;
  localparam int unsigned DA_W = 12;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_NEXT = 8'h08;
  localparam logic [7:0] OFS_WREG = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_TBL_PTR = 8'h14;
  localparam logic [7:0] OFS_TBLLAT = 8'h18;
  localparam logic [7:0] OFS_BANK = 8'h1c;
  localparam logic [7:0] OFS_FSR0 = 8'h20;
  localparam logic [7:0] OFS_FSR1 = 8'h24;
  localparam logic [7:0] OFS_FSR2 = 8'h28;
  localparam logic [7:0] OFS_PC = 8'h2c;
  localparam logic [7:0] OFS_TOS = 8'h30;
  localparam logic [7:0] OFS_DADDR = 8'h34;
  localparam logic [7:0] OFS_DDATA = 8'h38;
  localparam logic [7:0] OFS_HOLD0 = 8'h40;
  // field positions
  localparam int unsigned CTRL_EXT_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_Z_BIT = 1;
  localparam int unsigned ST_N_BIT = 2;
  localparam int unsigned ST_SKIP_BIT = 3;
  localparam int unsigned ST_CYC_LSB = 4;
  // reset values
  localparam logic RST_EXT = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'hff;
  localparam logic [15:0] RST_OP = 16'h0000;
  localparam logic [TP_W-1:0] RST_ADDR21 = 21'h000000;
  localparam logic [DA_W-1:0] RST_ADDR12 = 12'h000;
  // timing
  localparam logic [1:0] Q_READ = 2'h1;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [TP_W-1:0] PC_WORD = 21'h000002;
  localparam logic [TP_W-1:0] TP_ONE = 21'h000001;
  // table pointer modes
  localparam logic [1:0] TBL_KEEP = 2'h0;
  localparam logic [1:0] TBL_POSTINC = 2'h1;
  localparam logic [1:0] TBL_POSTDEC = 2'h2;
  localparam logic [1:0] TBL_PREINC = 2'h3;
  // opcode patterns
  localparam logic [13:0] OPC_TBL_WRITE = 14'h0003;
  localparam logic [6:0] OPC_TEST_SKIP = 7'h33;
  localparam logic [7:0] OPC_XOR_LIT = 8'h0a;
  localparam logic [5:0] OPC_XOR_REG = 6'h06;
  localparam logic [7:0] OPC_ADD_PTR = 8'he8;
  localparam logic [7:0] OPC_SUB_PTR = 8'he9;
  localparam logic [1:0] PTR_RETURN = 2'h3;
  localparam logic [3:0] OPC_MOVFF = 4'hc;
  localparam logic [6:0] OPC_CALL = 7'h76;
  localparam logic [7:0] OPC_LFSR = 8'hee;
  localparam logic [7:0] OPC_GOTO = 8'hef;
  localparam logic [7:0] OPC_MOVS = 8'heb;
  localparam logic [7:0] ACCESS_SPLIT = 8'h5f;
  localparam logic [3:0] ACCESS_HI = 4'hf;
  typedef enum logic [3:0] {
    K_NOP, K_TBL_WRITE, K_TST, K_XOR_LIT, K_XOR_REG, K_ADD_PTR, K_SUB_PTR, K_ADDRET, K_SUBRET
  } twxse_kind_t;
endpackage : twxse_pkg

// ---- src/twxse_qseq.sv ----
// Purpose: four-phase instruction cycle sequencer
// Assumes: start is a one-cycle pulse, only while idle
// Notes: busy stays high for exactly ncyc*4 clocks after the start edge
`timescale 1ns/1ns
`default_nettype none
module twxse_qseq (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [1:0] ncyc,
  output logic busy,
  output logic [1:0] qph,
  output logic [1:0] cyc
);
  logic busy_q, busy_d;
  logic [1:0] q_q, q_d, cyc_q, cyc_d, n_q, n_d;
  always_comb begin
    busy_d = busy_q;
    q_d = q_q;
    cyc_d = cyc_q;
    n_d = n_q;
    if (start) begin
      busy_d = 1'b1;
      q_d = 2'h0;
      cyc_d = 2'h0;
      n_d = ncyc;
    end else if (busy_q) begin
      q_d = q_q + 2'h1;
      if (q_q == twxse_pkg::Q_LAST) begin
        if (cyc_q == n_q - 2'h1) begin
          busy_d = 1'b0;
        end else begin
          cyc_d = cyc_q + 2'h1;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      q_q <= 2'h0;
      cyc_q <= 2'h0;
      n_q <= twxse_pkg::CYC_ONE;
    end else begin
      busy_q <= busy_d;
      q_q <= q_d;
      cyc_q <= cyc_d;
      n_q <= n_d;
    end
  end
  assign busy = busy_q;
  assign qph = q_q;
  assign cyc = cyc_q;
endmodule : twxse_qseq
`default_nettype wire

// ---- tb/tb_table_write_xor_skip_exec.sv ----
// Purpose: self-checking bench for the table write, xor and skip execution core
// Assumes: Avalon-MM master on CLK, waitrequest and read data taken at the rising edge
// Notes: a write to unmapped 8'hfc stalls until the running instruction ends
`timescale 1ns/1ns
`default_nettype none
module tb_table_write_xor_skip_exec;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  int bad_count = 0;
  int check_count = 0;
  twxse_core dut_u (.CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
  always #5 CLK = ~CLK;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (check_count > 0 && bad_count == 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // idle edge first so a release and a new request never share a time step
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    logic ok;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_READ <= rd;
    AVS_WRITE <= !rd;
    AVS_WRITEDATA <= d;
    do begin
      @(posedge CLK);
      ok = (AVS_WAITREQUEST === 1'b0);
      q = AVS_READDATA;
    end while (!ok);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    chk(q & m, e);
  endtask : rdc
  task automatic exec(input logic [15:0] op);
    wr(twxse_pkg::OFS_INSTR, {16'h0, op});
    wr(8'hfc, 32'h0);
  endtask : exec
  task automatic t_reset();
    rdc(twxse_pkg::OFS_CTRL, 32'h1, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rdc(twxse_pkg::OFS_HOLD0 + 8'(4 * i), 32'hff, 32'hff);
    end
    rdc(8'hfc, 32'hffffffff, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_table_write_op();
    logic [20:0] p [4] = '{21'h00a356, 21'h1fffff, 21'h000000, 21'h01389a};
    logic [20:0] np [4] = '{21'h00a356, 21'h000000, 21'h1fffff, 21'h01389b};
    int hi [4] = '{6, 7, 0, 3};
    for (int m = 0; m < 4; m++) begin
      wr(twxse_pkg::OFS_TBL_PTR, {11'h0, p[m]});
      wr(twxse_pkg::OFS_TBLLAT, 32'h30 + 32'(m));
      wr(twxse_pkg::OFS_STATUS, 32'h6);
      exec({twxse_pkg::OPC_TBL_WRITE, 2'(m)});
      rdc(twxse_pkg::OFS_TBL_PTR, 32'h1fffff, {11'h0, np[m]});
      rdc(twxse_pkg::OFS_HOLD0 + 8'(4 * hi[m]), 32'hff, 32'h30 + 32'(m));
      rdc(twxse_pkg::OFS_STATUS, 32'h36, 32'h26);
    end
    $display("test table write done");
  endtask : t_table_write_op
  task automatic t_xor();
    wr(twxse_pkg::OFS_WREG, 32'hb5);
    wr(twxse_pkg::OFS_STATUS, 32'h0);
    exec({twxse_pkg::OPC_XOR_LIT, 8'haf});
    rdc(twxse_pkg::OFS_WREG, 32'hff, 32'h1a);
    rdc(twxse_pkg::OFS_STATUS, 32'h36, 32'h10);
    exec({twxse_pkg::OPC_XOR_LIT, 8'h1a});
    rdc(twxse_pkg::OFS_STATUS, 32'h6, 32'h2);
    wr(twxse_pkg::OFS_WREG, 32'hb5);
    wr(twxse_pkg::OFS_DADDR, 32'hf80);
    wr(twxse_pkg::OFS_DDATA, 32'haf);
    exec({twxse_pkg::OPC_XOR_REG, 2'b10, 8'h80});
    rdc(twxse_pkg::OFS_DDATA, 32'hff, 32'h1a);
    rdc(twxse_pkg::OFS_WREG, 32'hff, 32'hb5);
    wr(twxse_pkg::OFS_BANK, 32'h3);
    wr(twxse_pkg::OFS_DADDR, 32'h310);
    wr(twxse_pkg::OFS_DDATA, 32'h47);
    exec({twxse_pkg::OPC_XOR_REG, 2'b01, 8'h10});
    rdc(twxse_pkg::OFS_WREG, 32'hff, 32'hf2);
    rdc(twxse_pkg::OFS_STATUS, 32'h6, 32'h4);
    rdc(twxse_pkg::OFS_DDATA, 32'hff, 32'h47);
    $display("test xor done");
  endtask : t_xor
  task automatic t_skip();
    logic [15:0] nx [3] = '{16'h0000, 16'hc000, 16'h0000};
    logic [7:0] dv [3] = '{8'h00, 8'h00, 8'h05};
    logic [31:0] pc [3] = '{32'h104, 32'h10a, 32'h10c};
    logic [31:0] st [3] = '{32'h2e, 32'h3e, 32'h16};
    wr(twxse_pkg::OFS_PC, 32'h100);
    for (int i = 0; i < 3; i++) begin
      wr(twxse_pkg::OFS_DADDR, 32'h20);
      wr(twxse_pkg::OFS_DDATA, {24'h0, dv[i]});
      wr(twxse_pkg::OFS_NEXT, {16'h0, nx[i]});
      wr(twxse_pkg::OFS_STATUS, 32'h6);
      exec({twxse_pkg::OPC_TEST_SKIP, 1'b0, 8'h20});
      rdc(twxse_pkg::OFS_STATUS, 32'h3e, st[i]);
      rdc(twxse_pkg::OFS_PC, 32'h1fffff, pc[i]);
    end
    $display("test skip done");
  endtask : t_skip
  task automatic t_ext();
    wr(twxse_pkg::OFS_FSR2, 32'h3ff);
    exec({twxse_pkg::OPC_ADD_PTR, 2'h2, 6'h23});
    rdc(twxse_pkg::OFS_FSR2, 32'hfff, 32'h3ff);
    wr(twxse_pkg::OFS_CTRL, 32'h1);
    exec({twxse_pkg::OPC_ADD_PTR, 2'h2, 6'h23});
    rdc(twxse_pkg::OFS_FSR2, 32'hfff, 32'h422);
    wr(twxse_pkg::OFS_TOS, 32'h2af);
    exec({twxse_pkg::OPC_ADD_PTR, twxse_pkg::PTR_RETURN, 6'h01});
    rdc(twxse_pkg::OFS_FSR2, 32'hfff, 32'h423);
    rdc(twxse_pkg::OFS_PC, 32'h1fffff, 32'h2af);
    rdc(twxse_pkg::OFS_STATUS, 32'h30, 32'h20);
    wr(twxse_pkg::OFS_DADDR, 32'h10);
    wr(twxse_pkg::OFS_DDATA, 32'h1);
    wr(twxse_pkg::OFS_DADDR, 32'h433);
    wr(twxse_pkg::OFS_DDATA, 32'h0);
    wr(twxse_pkg::OFS_NEXT, 32'h0);
    exec({twxse_pkg::OPC_TEST_SKIP, 1'b0, 8'h10});
    rdc(twxse_pkg::OFS_STATUS, 32'h38, 32'h28);
    exec({twxse_pkg::OPC_SUB_PTR, 2'h2, 6'h23});
    rdc(twxse_pkg::OFS_FSR2, 32'hfff, 32'h400);
    $display("test extension done");
  endtask : t_ext
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    t_reset();
    t_table_write_op();
    t_xor();
    t_skip();
    t_ext();
    print_verdict();
  end
endmodule : tb_table_write_xor_skip_exec
`default_nettype wire
